// ==== override_supervisor_map.svh ====
// override supervisor: diagnostic codes and timing constants
// assumes a 20 MHz system clock
`ifndef OVERRIDE_SUPERVISOR_MAP_SVH
`define OVERRIDE_SUPERVISOR_MAP_SVH
`define CLK_HZ 20000000
`define OVR_LIMIT_MAX_S 600
`define OVR_LIMIT_DEFAULT_S 0
`define DIAG_IDLE 16'h0000
`define DIAG_DEMAND 16'h8002
`define DIAG_NOT_POSSIBLE 16'h8012
`define DIAG_POSSIBLE 16'h8022
`define DIAG_OVERRIDE 16'h8832
`define DIAG_RESET_ERR 16'hc011
`define DIAG_TIME_ERR 16'hc410
`define DIAG_RESET_VAL 16'h0000
`endif

// ==== override_pkg.sv ====
// override supervisor: shared types
// assumes the map header is compiled alongside
package override_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEMAND = 3'b001,
    ST_NOT_POSSIBLE = 3'b010,
    ST_POSSIBLE = 3'b011,
    ST_OVERRIDE = 3'b100,
    ST_RESET_ERR = 3'b101,
    ST_TIME_ERR = 3'b110
  } ovr_state_t;
  typedef logic [15:0] diag_t;
endpackage

// ==== ovr_timer_if.sv ====
// override supervisor: link between state logic and override timer
// assumes a single clock domain
`timescale 1ns/1ns
interface ovr_timer_if;
  logic run;
  logic clear;
  logic expired;
  modport ctrl (output run, output clear, input expired);
  modport tmr (input run, input clear, output expired);
endinterface

// ==== ovr_timer.sv ====
// override supervisor: maximum override duration counter
// assumes run/clear come from the supervisor on the same clock
`timescale 1ns/1ns
`include "override_supervisor_map.svh"
module ovr_timer #(
  parameter longint LIMIT_CYCLES = 64'sh1
) (
  input wire logic clk,
  input wire logic arst_n,
  ovr_timer_if.tmr t
);
  logic [39:0] count;

  // counts while running; held when stopped, cleared on request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 40'h0;
    end else if (t.clear) begin
      count <= 40'h0;
    end else if (t.run && count < 40'(LIMIT_CYCLES)) begin
      count <= count + 40'h1; // see RL2
    end
  end

  // a zero limit arrives as one cycle and expires one clock after the timer is started
  assign t.expired = t.run && (count >= 40'(LIMIT_CYCLES)); // see RL1
endmodule // ovr_timer

// ==== muting_override_supervisor.sv ====
// override supervisor: gates the guard output during manual override
// assumes the muting block is evaluated earlier on the same clock edge
//
// Overview of operation
// RL1: limit is a parameter from zero to ten minutes, default zero.
// RL2: timer starts when override start conditions become present.
// RL3: timer stops once no muting sensor is actuated any more; the code also waits for a clear field.
// RL4: override starts only on a rising command edge, never on a level.
// RL5: command high with conditions met starts override and timer together.
// RL6: command low ends override; timer runs until muting completes.
// RL7: guard low when field broken and not muted, and override inactive.
// RL8: guard high when field clear, muting active, or override active.
// RL9: allowed flag high only while an override could be started.
// RL10: running flag high only while override is in progress.
// RL11: during override stop requests do not affect the guard output.
// RL12: surrounding logic evaluates the muting block before this one.
// RL13: upstream error and code are not copied to our outputs.
// RL14: override needs upstream fault, command edge held, field or sensor.
// RL15: override ends when all clear, time expires, or command drops.
// RL16: error on static acknowledge input and on time expiry.
// RL17: sensors c and d ignored for the two-sensor upstream variant.
// RL18: error sets flag, clears status, shows code; acknowledge edge clears.
// RL19: time expiry gives code c410, guard low and error.
// RL20: inactive block idles with code 0000 and all outputs low.
// RL21: upstream fault with field broken or sensor blocked gives 8022.
// RL22: edges found by comparing with previous cycle sample.
// RL23: diagnostic code is sixteen bits, zero after reset.
`timescale 1ns/1ns
`include "override_supervisor_map.svh"
module muting_override_supervisor #(
  parameter int OVR_TIME_S = `OVR_LIMIT_DEFAULT_S,
  parameter bit TWO_SENSOR = 1'b0,
  // ten minutes of cycles overflow an int, so the limit is a 64-bit longint; the timer count is 40 bits
  parameter longint LIMIT_CYCLES =
    (longint'(OVR_TIME_S) * `CLK_HZ < 64'sh1) ? 64'sh1 :
    longint'(OVR_TIME_S) * `CLK_HZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic activate,
  input wire logic light_curtain_input,
  input wire logic upstream_guard_state,
  input wire logic upstream_fault,
  input wire logic muting_sensor_a,
  input wire logic muting_sensor_b,
  input wire logic muting_sensor_c,
  input wire logic muting_sensor_d,
  input wire logic override_command,
  input wire logic acknowledge,
  output logic ready,
  output logic guard_output,
  output logic override_allowed_flag,
  output logic override_running_flag,
  output logic protection_request_flag,
  output logic acknowledge_request_flag,
  output logic error,
  output override_pkg::diag_t diagnostic_code
);
  import override_pkg::*;

  ovr_state_t state;
  ovr_state_t next_state;
  logic cmdPrev;
  logic ackPrev;
  logic cmdRise;
  logic ackRise;
  logic anySensor;
  logic fieldOrSensor;
  logic timing;
  ovr_timer_if tif ();

  // error states force the guard low and stop the timer
  function automatic logic isErrorState(input ovr_state_t s);
    return s == ST_RESET_ERR || s == ST_TIME_ERR;
  endfunction

  // limit range checked at elaboration; a bad value stops the build
  if (OVR_TIME_S < 0 || OVR_TIME_S > `OVR_LIMIT_MAX_S) begin : g_range
    $error("override time limit out of range"); // see RL1
  end

  ovr_timer #(.LIMIT_CYCLES(LIMIT_CYCLES)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .t(tif.tmr)
  );

  // previous-cycle samples for edge detection; inputs are same-clock logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdPrev <= 1'b0;
      ackPrev <= 1'b0;
    end else begin
      cmdPrev <= override_command; // see RL22
      ackPrev <= acknowledge;
    end
  end

  assign cmdRise = override_command && !cmdPrev; // see RL4
  assign ackRise = acknowledge && !ackPrev; // see RL22
  // unused sensors float on the two-sensor variant, so mask them
  assign anySensor = muting_sensor_a || muting_sensor_b ||
    (!TWO_SENSOR && (muting_sensor_c || muting_sensor_d)); // see RL17
  assign fieldOrSensor = !light_curtain_input || anySensor;

  // timer runs from override start until sensors and field clear, even past a drop
  // of the command; it is cleared once stopped in any state but override
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timing <= 1'b0;
    end else if (!activate || (!anySensor && light_curtain_input)) begin
      timing <= 1'b0; // see RL3
    end else if (state == ST_POSSIBLE && next_state == ST_OVERRIDE) begin
      timing <= 1'b1; // see RL5
    end else if (isErrorState(state)) begin
      timing <= 1'b0;
    end
  end

  assign tif.run = timing;
  assign tif.clear = !timing && state != ST_OVERRIDE; // see RL6

  // state transitions; upstream error codes are never mirrored
  always_comb begin
    next_state = state;
    if (!activate) begin
      next_state = ST_IDLE; // see RL20
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (acknowledge) begin
            next_state = ST_RESET_ERR; // see RL16
          end else begin
            next_state = ST_DEMAND;
          end
        end
        ST_DEMAND, ST_NOT_POSSIBLE, ST_POSSIBLE: begin
          if (tif.expired) begin
            next_state = ST_TIME_ERR; // see RL19
          end else if (!upstream_fault) begin
            next_state = ST_DEMAND; // see RL13
          end else if (!fieldOrSensor) begin
            next_state = ST_NOT_POSSIBLE;
          end else if (state == ST_POSSIBLE && cmdRise) begin
            next_state = ST_OVERRIDE; // see RL14
          end else begin
            next_state = ST_POSSIBLE; // see RL21
          end
        end
        ST_OVERRIDE: begin
          if (tif.expired) begin
            next_state = ST_TIME_ERR; // see RL15
          end else if (!override_command || !fieldOrSensor) begin
            next_state = ST_DEMAND; // see RL15
          end
        end
        ST_RESET_ERR, ST_TIME_ERR: begin
          if (ackRise) begin
            next_state = ST_DEMAND; // see RL18
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // registered outputs decoded from the next state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b0;
      guard_output <= 1'b0;
      override_allowed_flag <= 1'b0;
      override_running_flag <= 1'b0;
      protection_request_flag <= 1'b0;
      acknowledge_request_flag <= 1'b0;
      error <= 1'b0;
      diagnostic_code <= `DIAG_RESET_VAL; // see RL23
    end else begin
      ready <= next_state != ST_IDLE;
      // override bypasses stop requests; otherwise follow muted guard
      guard_output <= (next_state == ST_OVERRIDE) ||
        (activate && next_state != ST_IDLE &&
         !isErrorState(next_state) &&
         upstream_guard_state); // see RL7 see RL8 see RL11
      override_allowed_flag <= next_state == ST_POSSIBLE; // see RL9
      override_running_flag <= next_state == ST_OVERRIDE; // see RL10
      protection_request_flag <= 1'b0;
      acknowledge_request_flag <= next_state == ST_TIME_ERR &&
        !acknowledge;
      error <= isErrorState(next_state); // see RL18
      unique case (next_state)
        ST_IDLE: diagnostic_code <= `DIAG_IDLE;
        ST_DEMAND: diagnostic_code <= `DIAG_DEMAND;
        ST_NOT_POSSIBLE: diagnostic_code <= `DIAG_NOT_POSSIBLE;
        ST_POSSIBLE: diagnostic_code <= `DIAG_POSSIBLE;
        ST_OVERRIDE: diagnostic_code <= `DIAG_OVERRIDE;
        ST_RESET_ERR: diagnostic_code <= `DIAG_RESET_ERR;
        ST_TIME_ERR: diagnostic_code <= `DIAG_TIME_ERR; // see RL19
        default: diagnostic_code <= `DIAG_IDLE;
      endcase
    end
  end

  // all checks run on the system clock and rest while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // inactive block
  idle_outputs_a: assert property ( // see RL20
    !activate |=> !guard_output && !error && diagnostic_code == 16'h0000)
    else $error("outputs not idle while inactive");

  // starting an override
  level_no_start_a: assert property ( // see RL4
    state != ST_OVERRIDE && $past(override_command) && override_command
    |=> !override_running_flag)
    else $error("override started on a held level");
  start_needs_fault_a: assert property ( // see RL14
    $rose(override_running_flag) |-> $past(upstream_fault))
    else $error("override without upstream fault");
  start_with_timer_a: assert property ( // see RL5
    $rose(override_running_flag) |-> tif.run)
    else $error("override started without its timer");
  timer_start_a: assert property ( // see RL2
    $rose(tif.run) |-> override_running_flag)
    else $error("timer started outside an override start");

  // running an override
  run_needs_command_a: assert property ( // see RL10 see RL15
    override_running_flag |-> $past(override_command))
    else $error("running flag without a held command");
  cmd_drop_ends_a: assert property ( // see RL15
    state == ST_OVERRIDE && !override_command |=> !override_running_flag)
    else $error("override kept after command drop");
  timer_past_drop_a: assert property ( // see RL6
    activate && state == ST_OVERRIDE && !override_command && fieldOrSensor
    |=> tif.run)
    else $error("timer stopped on command drop");
  timer_stops_a: assert property ( // see RL3
    !anySensor && light_curtain_input |=> !tif.run)
    else $error("timer kept running with sensors clear");
  override_guard_a: assert property ( // see RL11
    override_running_flag |-> guard_output)
    else $error("guard low during override");

  // status flags and codes
  possible_flags_a: assert property ( // see RL21 see RL9
    activate && upstream_fault && fieldOrSensor && !tif.expired &&
    (state == ST_DEMAND || state == ST_NOT_POSSIBLE)
    |=> override_allowed_flag && diagnostic_code == 16'h8022)
    else $error("override possible not reported");
  allowed_needs_fault_a: assert property ( // see RL9
    override_allowed_flag |-> $past(upstream_fault) && $past(fieldOrSensor))
    else $error("allowed flag without its conditions");
  allowed_code_a: assert property ( // see RL21
    override_allowed_flag |-> diagnostic_code == 16'h8022)
    else $error("allowed flag without matching code");
  sensors_masked_a: assert property ( // see RL17
    TWO_SENSOR && light_curtain_input && !muting_sensor_a &&
    !muting_sensor_b |=> !override_allowed_flag)
    else $error("unused sensors counted on two-sensor variant");
  no_mirror_a: assert property ( // see RL13
    activate && upstream_fault && !tif.expired && state == ST_DEMAND
    |=> !error)
    else $error("upstream fault copied to error");
  guard_follows_a: assert property ( // see RL7 see RL8
    activate && !upstream_fault && !tif.expired &&
    state inside {ST_DEMAND, ST_NOT_POSSIBLE, ST_POSSIBLE}
    |=> guard_output == $past(upstream_guard_state))
    else $error("guard does not follow muted guard");

  // errors
  time_error_code_a: assert property ( // see RL19
    activate && tif.expired && state != ST_IDLE && state < ST_RESET_ERR
    |=> error && diagnostic_code == 16'hc410 && !guard_output)
    else $error("expiry not reported");
  static_ack_a: assert property ( // see RL16
    state == ST_IDLE && activate && acknowledge |=> error &&
    diagnostic_code == 16'hc011)
    else $error("static acknowledge not flagged");
  error_clears_flags_a: assert property ( // see RL18
    error |-> !override_allowed_flag && !override_running_flag)
    else $error("status flags set during error");
  error_guard_low_a: assert property ( // see RL7 see RL19
    error |-> !guard_output)
    else $error("guard high during error");
  error_sticky_a: assert property ( // see RL18
    error && activate && !ackRise |=> error)
    else $error("error cleared without acknowledge edge");
  ack_edge_clears_a: assert property ( // see RL18
    error && activate && ackRise |=> !error && diagnostic_code == 16'h8002)
    else $error("acknowledge edge did not clear error");
  ack_request_a: assert property ( // see RL19
    acknowledge_request_flag |-> error && diagnostic_code == 16'hc410)
    else $error("acknowledge request outside expiry error");

  // main scenarios reached
  override_seen_c: cover property ($rose(override_running_flag));
  allowed_seen_c: cover property ($rose(override_allowed_flag));
  timeout_seen_c: cover property ($rose(error) && diagnostic_code == 16'hc410);
  recover_seen_c: cover property ($fell(error) && activate);
  static_seen_c: cover property ($rose(error) && diagnostic_code == 16'hc011);
endmodule // muting_override_supervisor

// ==== muting_partner.sv ====
// far side model: upstream muting block outputs and operator switch
// assumes the bench sets targets; outputs change on the rising edge
`timescale 1ns/1ns
module muting_partner (
  input wire logic clk,
  input wire logic arst_n,
  output logic guardState,
  output logic fault,
  output logic [3:0] sensors,
  output logic command
);
  logic next_guard = 1'b0;
  logic next_fault = 1'b0;
  logic next_cmd = 1'b0;
  logic [3:0] next_sensors = 4'h0;

  // upstream is evaluated first, so the supervisor sees settled values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      guardState <= 1'b0;
      fault <= 1'b0;
      sensors <= 4'h0;
      command <= 1'b0;
    end else begin
      guardState <= next_guard;
      fault <= next_fault;
      sensors <= next_sensors;
      command <= next_cmd; // clean step, a held level stays held
    end
  end

  // targets land at the next edge, never mid-cycle
  task automatic setAll(input logic g, input logic f, input logic [3:0] s,
      input logic c);
    next_guard <= g;
    next_fault <= f;
    next_sensors <= s;
    next_cmd <= c;
  endtask
endmodule // muting_partner

// ==== muting_override_supervisor_tb_top.sv ====
// bench for the override supervisor: scenario tasks and verdict
// assumes the partner model drives the upstream and switch inputs
`timescale 1ns/1ns
`include "override_supervisor_map.svh"
module muting_override_supervisor_tb_top;
  import override_pkg::*;
  localparam int LIMIT = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic activate = 1'b0;
  logic lightCurtain = 1'b0;
  logic ack = 1'b0;
  logic ready, guard, allowed, running, protReq, ackReq, err;
  logic guardState, fault, command;
  logic [3:0] sensors;
  diag_t code;
  logic allowed4;
  diag_t code4;
  int mismatches = 0;
  int check_count = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  muting_partner p (.clk(clk), .arst_n(arst_n), .guardState(guardState),
    .fault(fault), .sensors(sensors), .command(command));

  // short limit keeps the expiry run brief; two-sensor variant
  muting_override_supervisor #(.LIMIT_CYCLES(LIMIT), .TWO_SENSOR(1'b1)) DUT (
    .clk(clk), .arst_n(arst_n), .activate(activate),
    .light_curtain_input(lightCurtain), .upstream_guard_state(guardState),
    .upstream_fault(fault), .muting_sensor_a(sensors[0]),
    .muting_sensor_b(sensors[1]), .muting_sensor_c(sensors[2]),
    .muting_sensor_d(sensors[3]), .override_command(command),
    .acknowledge(ack), .ready(ready), .guard_output(guard),
    .override_allowed_flag(allowed), .override_running_flag(running),
    .protection_request_flag(protReq), .acknowledge_request_flag(ackReq),
    .error(err), .diagnostic_code(code));

  // four-sensor variant shares the stimulus; only its sensor use differs
  muting_override_supervisor #(.LIMIT_CYCLES(LIMIT), .TWO_SENSOR(1'b0))
    DUT4 (
    .clk(clk), .arst_n(arst_n), .activate(activate),
    .light_curtain_input(lightCurtain), .upstream_guard_state(guardState),
    .upstream_fault(fault), .muting_sensor_a(sensors[0]),
    .muting_sensor_b(sensors[1]), .muting_sensor_c(sensors[2]),
    .muting_sensor_d(sensors[3]), .override_command(command),
    .acknowledge(ack), .ready(), .guard_output(),
    .override_allowed_flag(allowed4), .override_running_flag(),
    .protection_request_flag(), .acknowledge_request_flag(),
    .error(), .diagnostic_code(code4));

  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // partner adds one edge, supervisor one more, so three edges settle it
  task automatic apply(input logic act, input logic lc, input logic ak,
      input logic g, input logic f, input logic [3:0] s, input logic c);
    @(posedge clk);
    activate <= act;
    lightCurtain <= lc;
    ack <= ak;
    p.setAll(g, f, s, c);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_idle;
    check("code", code, `DIAG_RESET_VAL);
    apply(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0);
    check("guard", guard, 1'b0);
    check("ready", ready, 1'b0);
    check("code", code, `DIAG_IDLE);
  endtask

  task automatic t_demand;
    apply(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0);
    check("code", code, `DIAG_DEMAND);
    check("guard", guard, 1'b1);
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 1'b0);
    check("guard", guard, 1'b0);
    check("prot", protReq, 1'b0);
  endtask

  // command already high when override becomes possible must not start it
  task automatic t_possible;
    apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 1'b1);
    check("code", code, `DIAG_POSSIBLE);
    check("allowed", allowed, 1'b1);
    check("running", running, 1'b0);
    check("error", err, 1'b0);
    apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hc, 1'b0);
    check("code", code, `DIAG_NOT_POSSIBLE);
    check("allowed", allowed, 1'b0);
    check("code4", code4, `DIAG_POSSIBLE);
    check("allowed4", allowed4, 1'b1);
  endtask

  // start, drop, then clear the field so the timer stops before expiry
  task automatic t_override;
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 1'b1);
    check("code", code, `DIAG_OVERRIDE);
    check("running", running, 1'b1);
    check("guard", guard, 1'b1);
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
    check("running", running, 1'b0);
    check("guard", guard, 1'b0);
    apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
    repeat (LIMIT + 10) @(posedge clk);
    #1;
    check("error", err, 1'b0);
    check("code", code, `DIAG_NOT_POSSIBLE);
  endtask

  task automatic t_timeout;
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 1'b0);
    apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 1'b1);
    repeat (LIMIT) @(posedge clk);
    #1;
    check("code", code, `DIAG_TIME_ERR);
    check("guard", guard, 1'b0);
    check("error", err, 1'b1);
    check("allowed", allowed, 1'b0);
    check("running", running, 1'b0);
    check("ackreq", ackReq, 1'b1);
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    check("error", err, 1'b0);
    check("code", code, `DIAG_DEMAND);
  endtask

  task automatic t_static;
    apply(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    check("code", code, `DIAG_RESET_ERR);
    check("error", err, 1'b1);
    check("ready", ready, 1'b1);
    apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    check("error", err, 1'b1);
    apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    check("error", err, 1'b0);
  endtask

  // main sequence: reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    t_idle();
    t_demand();
    t_possible();
    t_override();
    t_timeout();
    t_static();
    test_done();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    #(2000 * 50);
    mismatches++;
    test_done();
  end
endmodule // muting_override_supervisor_tb_top
